/* File: design/tmec_top.sv */
// Two 8-bit timer/event counters with their mode, clock, compare and pin-direction registers
`timescale 1ns/1ps
`default_nettype none
`include "tmec_defs.svh"
module tmec_top (
    // Clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_arst_n,
    // Register port
    input  wire tmec_pkg::tmec_addr_t i_addr,
    input  wire tmec_pkg::tmec_byte_t i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output tmec_pkg::tmec_byte_t     o_rdata,
    // Timer A shared pin
    input  wire logic                i_pin_a_in,
    output logic                     o_pin_a_out,
    output logic                     o_pin_a_oe,
    // Timer B shared pin
    input  wire logic                i_pin_b_in,
    output logic                     o_pin_b_out,
    output logic                     o_pin_b_oe,
    // Match requests
    output logic                     o_match_irq_a,
    output logic                     o_match_irq_b,
    // Port state for the rest of the port logic
    output tmec_pkg::tmec_byte_t     o_port1_direction,
    output tmec_pkg::tmec_byte_t     o_port3_direction,
    output tmec_pkg::tmec_byte_t     o_port1_latch,
    output tmec_pkg::tmec_byte_t     o_port3_latch
);
    import tmec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Shared prescaler

    logic [`TMEC_DIV_W:0] tick;

    tmec_prescaler u_prescaler (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .o_tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Port direction and latch registers

    tmec_byte_t port1_direction_q;
    tmec_byte_t port1_direction_d;
    tmec_byte_t port3_direction_q;
    tmec_byte_t port3_direction_d;
    tmec_byte_t port1_latch_q;
    tmec_byte_t port1_latch_d;
    tmec_byte_t port3_latch_q;
    tmec_byte_t port3_latch_d;

    always_comb begin
        port1_direction_d = port1_direction_q;
        port3_direction_d = port3_direction_q;
        port1_latch_d     = port1_latch_q;
        port3_latch_d     = port3_latch_q;
        if (i_wr) begin
            case (i_addr)
                `TMEC_ADR_DIR1: begin
                    port1_direction_d = i_wdata;
                end
                `TMEC_ADR_DIR3: begin
                    // Upper half has no pins and stays in input mode
                    port3_direction_d = `TMEC_DIR3_FIXED | i_wdata;
                end
                `TMEC_ADR_LAT1: begin
                    port1_latch_d = i_wdata;
                end
                `TMEC_ADR_LAT3: begin
                    port3_latch_d = i_wdata;
                end
                default: begin
                    port1_latch_d = port1_latch_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port1_direction_q <= `TMEC_DIR_RST;
            port3_direction_q <= `TMEC_DIR_RST;
            port1_latch_q     <= `TMEC_LAT_RST;
            port3_latch_q     <= `TMEC_LAT_RST;
        end else begin
            port1_direction_q <= port1_direction_d;
            port3_direction_q <= port3_direction_d;
            port1_latch_q     <= port1_latch_d;
            port3_latch_q     <= port3_latch_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer channels: index 0 is timer A, index 1 is timer B

    tmec_byte_t mode_v   [2];
    tmec_byte_t clk_v    [2];
    tmec_byte_t cmp_v    [2];
    tmec_byte_t cnt_v    [2];
    logic       pout_v   [2];
    logic       poe_v    [2];
    logic       irq_v    [2];

    for (genvar g = 0; g < 2; g++) begin : g_ch
        localparam tmec_addr_t ADR_MODE = (g == 0) ? `TMEC_ADR_MODE_A : `TMEC_ADR_MODE_B;
        localparam tmec_addr_t ADR_CLK  = (g == 0) ? `TMEC_ADR_CLK_A  : `TMEC_ADR_CLK_B;
        localparam tmec_addr_t ADR_CMP  = (g == 0) ? `TMEC_ADR_CMP_A  : `TMEC_ADR_CMP_B;

        tmec_byte_t   mode_q;
        tmec_byte_t   mode_d;
        tmec_byte_t   clk_q;
        tmec_byte_t   clk_d;
        tmec_byte_t   cmp_q;
        tmec_byte_t   cmp_d;
        tmec_byte_t   pwm_cmp_q;
        tmec_byte_t   pwm_cmp_d;
        tmec_byte_t   cnt_q;
        tmec_byte_t   cnt_d;
        logic         flop_q;
        logic         flop_d;
        logic         act_q;
        logic         act_d;
        logic         irq_q;
        logic         irq_d;
        logic         pout_q;
        logic         pout_d;
        logic         poe_q;
        logic         poe_d;
        logic         wave_d;
        logic         wr_mode;
        logic         run_n;
        logic         pwm_n;
        logic         count_en;
        logic         event_edge;
        logic         pin_in;
        logic         pin_dir_n;
        logic         pin_lat_n;
        tmec_preset_e preset;
        tmec_clk_e    clk_sel;

        assign pin_in    = (g == 0) ? i_pin_a_in : i_pin_b_in;
        assign pin_dir_n = (g == 0) ? port1_direction_d[`TMEC_PIN_A_BIT] : port3_direction_d[`TMEC_PIN_B_BIT];
        assign pin_lat_n = (g == 0) ? port1_latch_d[`TMEC_PIN_A_BIT] : port3_latch_d[`TMEC_PIN_B_BIT];

        tmec_edge_sync u_edge (
            .i_mclk     (i_mclk),
            .i_arst_n   (i_arst_n),
            .i_pin      (pin_in),
            .i_rise_sel (clk_q[0]),
            .o_edge     (event_edge)
        );

        // Count clock selection; the two channels differ in taps 4 and 7
        always_comb begin
            clk_sel = tmec_clk_e'(clk_q[2:0]);
            case (clk_sel)
                TMEC_CK_FALL:   count_en = event_edge;
                TMEC_CK_RISE:   count_en = event_edge;
                TMEC_CK_DIV1:   count_en = tick[0];
                TMEC_CK_DIV2:   count_en = tick[1];
                TMEC_CK_DIVC:   count_en = (g == 0) ? tick[2] : tick[4];
                TMEC_CK_DIV64:  count_en = tick[6];
                TMEC_CK_DIV256: count_en = tick[8];
                TMEC_CK_DIVF:   count_en = (g == 0) ? tick[13] : tick[12];
                default:        count_en = 1'b0;
            endcase
        end

        // Register writes, counter, output flop and pin drive
        always_comb begin
            wr_mode   = i_wr && (i_addr == ADR_MODE);
            mode_d    = mode_q;
            clk_d     = clk_q;
            cmp_d     = cmp_q;
            pwm_cmp_d = pwm_cmp_q;
            cnt_d     = cnt_q;
            flop_d    = flop_q;
            act_d     = act_q;
            irq_d     = 1'b0;
            preset    = TMEC_PSET_KEEP;
            if (wr_mode) begin
                // Preset bits are stored, but they only act on the write
                mode_d = i_wdata & `TMEC_MODE_WMASK & ~`TMEC_MODE_RMASK | (i_wdata & `TMEC_MODE_RMASK);
                preset = tmec_preset_e'({i_wdata[`TMEC_BIT_PSET_HI], i_wdata[`TMEC_BIT_PSET_LO]});
            end
            if (i_wr && (i_addr == ADR_CLK)) begin
                clk_d = i_wdata & `TMEC_CLK_WMASK;
            end
            if (i_wr && (i_addr == ADR_CMP)) begin
                cmp_d = i_wdata;
            end
            run_n = mode_d[`TMEC_BIT_RUN];
            pwm_n = mode_d[`TMEC_BIT_PWM];
            if (!run_n) begin
                cnt_d     = 8'h00;
                act_d     = 1'b0;
                pwm_cmp_d = cmp_q;
            end else if (count_en) begin
                if (!pwm_n) begin
                    if (cnt_q == cmp_q) begin
                        cnt_d = 8'h00;
                        irq_d = 1'b1;
                        if (mode_q[`TMEC_BIT_INV]) begin
                            flop_d = ~flop_q;
                        end
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end else begin
                    // Free-running; new compare value is taken at overflow, or while the run bit is low
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == `TMEC_CNT_MAX) begin
                        pwm_cmp_d = cmp_q;
                        act_d     = (cmp_q != 8'h00);
                    end else if ((cnt_q + 8'h01) == pwm_cmp_q) begin
                        act_d = 1'b0;
                    end
                end
            end
            if (!pwm_n) begin
                case (preset)
                    TMEC_PSET_LOW:  flop_d = 1'b0;
                    TMEC_PSET_HIGH: flop_d = 1'b1;
                    TMEC_PSET_KEEP: flop_d = flop_d;
                    default:        flop_d = flop_d;
                endcase
            end
            // Built from next values so settings reach the pin with the write
            if (!mode_d[`TMEC_BIT_OE]) begin
                wave_d = 1'b0;
            end else if (pwm_n) begin
                wave_d = act_d ^ mode_d[`TMEC_BIT_INV];
            end else begin
                wave_d = flop_d;
            end
            // Latch is ORed in, so timer output needs the latch cleared
            pout_d = wave_d | pin_lat_n;
            poe_d  = ~pin_dir_n;
        end

        always_ff @(posedge i_mclk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                mode_q    <= `TMEC_MODE_RST;
                clk_q     <= `TMEC_CLK_RST;
                cmp_q     <= `TMEC_CMP_RST;
                pwm_cmp_q <= `TMEC_CMP_RST;
                cnt_q     <= 8'h00;
                flop_q    <= 1'b0;
                act_q     <= 1'b0;
                irq_q     <= 1'b0;
                pout_q    <= 1'b0;
                poe_q     <= 1'b0;
            end else begin
                mode_q    <= mode_d;
                clk_q     <= clk_d;
                cmp_q     <= cmp_d;
                pwm_cmp_q <= pwm_cmp_d;
                cnt_q     <= cnt_d;
                flop_q    <= flop_d;
                act_q     <= act_d;
                irq_q     <= irq_d;
                pout_q    <= pout_d;
                poe_q     <= poe_d;
            end
        end

        assign mode_v[g] = mode_q;
        assign clk_v[g]  = clk_q;
        assign cmp_v[g]  = cmp_q;
        assign cnt_v[g]  = cnt_q;
        assign pout_v[g] = pout_q;
        assign poe_v[g]  = poe_q;
        assign irq_v[g]  = irq_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the strobe

    tmec_byte_t rdata_q;
    tmec_byte_t rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `TMEC_ADR_MODE_A: rdata_d = mode_v[0] & `TMEC_MODE_RMASK | (mode_v[0] & 8'h80);
                `TMEC_ADR_MODE_B: rdata_d = mode_v[1] & `TMEC_MODE_RMASK | (mode_v[1] & 8'h80);
                `TMEC_ADR_CLK_A:  rdata_d = clk_v[0];
                `TMEC_ADR_CLK_B:  rdata_d = clk_v[1];
                `TMEC_ADR_CMP_A:  rdata_d = cmp_v[0];
                `TMEC_ADR_CMP_B:  rdata_d = cmp_v[1];
                `TMEC_ADR_CNT_A:  rdata_d = cnt_v[0];
                `TMEC_ADR_CNT_B:  rdata_d = cnt_v[1];
                `TMEC_ADR_DIR1:   rdata_d = port1_direction_q;
                `TMEC_ADR_DIR3:   rdata_d = port3_direction_q;
                `TMEC_ADR_LAT1:   rdata_d = port1_latch_q;
                `TMEC_ADR_LAT3:   rdata_d = port3_latch_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_rdata           = rdata_q;
    assign o_pin_a_out       = pout_v[0];
    assign o_pin_a_oe        = poe_v[0];
    assign o_pin_b_out       = pout_v[1];
    assign o_pin_b_oe        = poe_v[1];
    assign o_match_irq_a     = irq_v[0];
    assign o_match_irq_b     = irq_v[1];
    assign o_port1_direction = port1_direction_q;
    assign o_port3_direction = port3_direction_q;
    assign o_port1_latch     = port1_latch_q;
    assign o_port3_latch     = port3_latch_q;
endmodule
`default_nettype wire

/* File: design/tmec_defs.svh */
// Register map, field positions, reset values and divider sizes of the timer/event counter pair
// Overview of operation
// - Run bit 7 low clears counter and holds it; high lets it count.
// - Mode bit 6: 0 clear-and-restart on match, 1 free-running PWM.
// - Preset bits 3,2: 00 keep, 01 flop to 0, 10 flop to 1; never 11.
// - Bit 1 enables toggle on match, or picks PWM polarity (1 = active low).
// - Output enable bit 0 low holds output low; high drives flop or PWM.
// - Preset bits act only outside PWM mode, ignored inside it.
// - In PWM mode clearing the run bit forces the inactive output level.
// - Preset bits are write-only and always read back as 0.
// - Mode, preset, polarity and enable reach the pin regardless of run bit.
// - Reset clears mode register to zero; bit and byte writes accepted.
// - Direction bit 0 means output buffer on, 1 input; reset to all ones.
// - Clear-and-restart: match zeroes counter, counting goes on, match request raised.
// - Clock-select bits 2..0 choose the counter clock source.
// - Event counting adds one per selected edge of the event pin.
// - Event counting outside PWM mode: every match clears counter and raises match request.
// - Counter steps on count clock; cleared by reset, run low, match.
// - Clock-select codes 0 and 1 pick falling and rising event pin edge.
`ifndef TMEC_DEFS_SVH
`define TMEC_DEFS_SVH

`define TMEC_ADR_MODE_A   16'hFF6B
`define TMEC_ADR_MODE_B   16'hFF43
`define TMEC_ADR_CLK_A    16'hFF6A
`define TMEC_ADR_CLK_B    16'hFF8C
`define TMEC_ADR_CMP_A    16'hFF6C
`define TMEC_ADR_CMP_B    16'hFF44
`define TMEC_ADR_CNT_A    16'hFF6D
`define TMEC_ADR_CNT_B    16'hFF45
`define TMEC_ADR_DIR1     16'hFF21
`define TMEC_ADR_DIR3     16'hFF23
`define TMEC_ADR_LAT1     16'hFF01
`define TMEC_ADR_LAT3     16'hFF03

`define TMEC_BIT_RUN      7
`define TMEC_BIT_PWM      6
`define TMEC_BIT_PSET_HI  3
`define TMEC_BIT_PSET_LO  2
`define TMEC_BIT_INV      1
`define TMEC_BIT_OE       0
`define TMEC_PIN_A_BIT    7
`define TMEC_PIN_B_BIT    3

`define TMEC_MODE_RST     8'h00
`define TMEC_CLK_RST      8'h00
`define TMEC_CMP_RST      8'h00
`define TMEC_DIR_RST      8'hFF
`define TMEC_LAT_RST      8'h00
`define TMEC_MODE_WMASK   8'hCF
`define TMEC_MODE_RMASK   8'hC3
`define TMEC_CLK_WMASK    8'h07
`define TMEC_DIR3_FIXED   8'hF0
`define TMEC_CNT_MAX      8'hFF

`define TMEC_DIV_W        13

`endif

/* File: design/tmec_pkg.sv */
// Types shared by the timer/event counter files
package tmec_pkg;
    typedef logic [7:0]  tmec_byte_t;
    typedef logic [15:0] tmec_addr_t;
    typedef enum logic [1:0] {
        TMEC_PSET_KEEP = 2'h0,
        TMEC_PSET_LOW  = 2'h1,
        TMEC_PSET_HIGH = 2'h2,
        TMEC_PSET_BAD  = 2'h3
    } tmec_preset_e;
    typedef enum logic [2:0] {
        TMEC_CK_FALL  = 3'h0,
        TMEC_CK_RISE  = 3'h1,
        TMEC_CK_DIV1  = 3'h2,
        TMEC_CK_DIV2  = 3'h3,
        TMEC_CK_DIVC  = 3'h4,
        TMEC_CK_DIV64 = 3'h5,
        TMEC_CK_DIV256 = 3'h6,
        TMEC_CK_DIVF  = 3'h7
    } tmec_clk_e;
endpackage

/* File: design/tmec_prescaler.sv */
// Free-running divider giving one-cycle enables at every power-of-two rate from 1 to 2**13 cycles
`timescale 1ns/1ps
`default_nettype none
`include "tmec_defs.svh"
module tmec_prescaler (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_arst_n,
    // Enables: bit k pulses once every 2**k cycles
    output logic [`TMEC_DIV_W:0]        o_tick
);
    logic [`TMEC_DIV_W-1:0] div_q;
    logic [`TMEC_DIV_W-1:0] div_d;
    logic [`TMEC_DIV_W:0]   tick_q;
    logic [`TMEC_DIV_W:0]   tick_d;

    always_comb begin
        div_d     = div_q + {{(`TMEC_DIV_W-1){1'b0}}, 1'b1};
    end

    assign tick_d[0] = 1'b1;
    for (genvar k = 1; k <= `TMEC_DIV_W; k++) begin : g_tap
        assign tick_d[k] = &div_q[k-1:0];
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_q  <= '0;
            tick_q <= '0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;
endmodule
`default_nettype wire

/* File: design/tmec_edge_sync.sv */
// Event pin synchroniser with selectable edge detector
`timescale 1ns/1ps
`default_nettype none
module tmec_edge_sync (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_arst_n,
    // Pin and edge choice
    input  wire logic i_pin,
    input  wire logic i_rise_sel,
    // One-cycle pulse per detected edge
    output logic      o_edge
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic edge_q;
    logic edge_d;

    // Only the second stage and its delayed copy feed the detector
    always_comb begin
        edge_d = i_rise_sel ? (sync_q & ~prev_q) : (~sync_q & prev_q);
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
            edge_q <= edge_d;
        end
    end

    assign o_edge = edge_q;
endmodule
`default_nettype wire

/* File: bench/tmec_assertions.sv */
// Port-level checker for the timer/event counter pair, bound to the top
`timescale 1ns/1ps
`default_nettype none
`include "tmec_defs.svh"
module tmec_checker (
    // Clock, reset and register port
    input wire logic                 i_mclk,
    input wire logic                 i_arst_n,
    input wire tmec_pkg::tmec_addr_t i_addr,
    input wire tmec_pkg::tmec_byte_t i_wdata,
    input wire logic                 i_wr,
    input wire logic                 i_rd,
    input wire tmec_pkg::tmec_byte_t o_rdata,
    // Timer A pin, request and port copies
    input wire logic                 o_pin_a_out,
    input wire logic                 o_pin_a_oe,
    input wire logic                 o_match_irq_a,
    input wire tmec_pkg::tmec_byte_t o_port1_direction,
    input wire tmec_pkg::tmec_byte_t o_port3_direction,
    input wire tmec_pkg::tmec_byte_t o_port1_latch
);
    import tmec_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    tmec_byte_t mode_q;
    tmec_byte_t mode_d;
    logic       wm;
    assign wm = i_wr && i_addr == `TMEC_ADR_MODE_A;
    // Shadow of stored mode bits
    always_comb begin
        mode_d = wm ? (i_wdata & 8'hcf) : mode_q;
    end
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    property p_mode_rd; i_rd && i_addr == `TMEC_ADR_MODE_A |=> o_rdata == (mode_q & 8'hc3); endproperty
    property p_dir_wr; i_wr && i_addr == `TMEC_ADR_DIR1 |=> o_port1_direction == $past(i_wdata); endproperty
    property p_oe_dir; o_pin_a_oe == !o_port1_direction[7]; endproperty
    property p_dir3_hi; o_port3_direction[7:4] == 4'hf; endproperty
    property p_oe_low; wm && !i_wdata[0] && !o_port1_latch[7] |=> !o_pin_a_out; endproperty
    property p_pset_hi; wm && !i_wdata[6] && i_wdata[3:2] == 2'b10 && i_wdata[0] |=> o_pin_a_out; endproperty
    property p_pset_lo;
        wm && !i_wdata[6] && i_wdata[3:2] == 2'b01 && i_wdata[0] && !o_port1_latch[7] |=> !o_pin_a_out;
    endproperty
    property p_pwm_idle;
        wm && i_wdata[7:6] == 2'b01 && i_wdata[0] && !o_port1_latch[7] |=> o_pin_a_out == $past(i_wdata[1]);
    endproperty
    property p_irq_mode; o_match_irq_a |-> mode_q[7] && !mode_q[6]; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
    a_dir_wr: assert property (p_dir_wr) else $error("direction not stored");
    a_oe_dir: assert property (p_oe_dir) else $error("pin enable not from direction");
    a_dir3_hi: assert property (p_dir3_hi) else $error("port3 upper bits not one");
    a_oe_low: assert property (p_oe_low) else $error("disabled output not low");
    a_pset_hi: assert property (p_pset_hi) else $error("preset high missed");
    a_pset_lo: assert property (p_pset_lo) else $error("preset low missed");
    a_pwm_idle: assert property (p_pwm_idle) else $error("stopped pwm not inactive");
    a_irq_mode: assert property (p_irq_mode) else $error("request outside running mode");
    c_irq: cover property (o_match_irq_a);
    c_pwm: cover property (wm && i_wdata[7:6] == 2'b11);
    c_cnt: cover property (i_rd && i_addr == `TMEC_ADR_CNT_A);
endmodule
bind tmec_top tmec_checker i_chk (.i_mclk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_pin_a_out, .o_pin_a_oe, .o_match_irq_a, .o_port1_direction, .o_port3_direction, .o_port1_latch);
`default_nettype wire

/* File: bench/tmec_pulse_src.sv */
// External pulse source standing on a timer's event pin
`timescale 1ns/1ps
`default_nettype none
module tmec_pulse_src (
    // Clock and pin level
    input  wire logic i_mclk,
    output var logic  o_pin
);
    initial begin
        o_pin = 1'b0;
    end
    // Levels held w cycles; below two the synchroniser may miss edges
    task automatic pulses(input int n, input int w);
        for (int k = 0; k < n; k++) begin
            repeat (w) @(posedge i_mclk);
            o_pin <= 1'b1;
            repeat (w) @(posedge i_mclk);
            o_pin <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the timer/event counter pair
`timescale 1ns/1ps
`default_nettype none
`include "tmec_defs.svh"
module tb;
    import tmec_pkg::*;
    logic       i_mclk, i_arst_n, i_wr, i_rd, irq_a, irq_b, src_a, src_b;
    logic       o_pin_a_out, o_pin_a_oe, o_pin_b_out, o_pin_b_oe;
    wire logic  pin_a, pin_b;
    tmec_addr_t i_addr;
    tmec_byte_t i_wdata, o_rdata;
    logic [31:0] lfsr_q;
    int         err_count, compares, nirq [2];
    tmec_addr_t amode [2] = '{`TMEC_ADR_MODE_A, `TMEC_ADR_MODE_B};
    tmec_addr_t aclk [2] = '{`TMEC_ADR_CLK_A, `TMEC_ADR_CLK_B};
    tmec_addr_t acmp [2] = '{`TMEC_ADR_CMP_A, `TMEC_ADR_CMP_B};
    tmec_addr_t acnt [2] = '{`TMEC_ADR_CNT_A, `TMEC_ADR_CNT_B};
    int         divs [2][8] = '{'{0, 0, 1, 2, 4, 64, 256, 8192}, '{0, 0, 1, 2, 16, 64, 256, 4096}};
    tmec_byte_t ptab [8] = '{8'h09, 8'h05, 8'h08, 8'h01, 8'h41, 8'h43, 8'h45, 8'h01};
    logic [7:0] etab = 8'ha9;
    tmec_top i_dut (.i_mclk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_pin_a_in(pin_a), .o_pin_a_out, .o_pin_a_oe, .i_pin_b_in(pin_b), .o_pin_b_out, .o_pin_b_oe,
        .o_match_irq_a(irq_a), .o_match_irq_b(irq_b), .o_port1_direction(), .o_port3_direction(),
        .o_port1_latch(), .o_port3_latch());
    tmec_pulse_src i_src_a (.i_mclk, .o_pin(src_a));
    tmec_pulse_src i_src_b (.i_mclk, .o_pin(src_b));
    // Enabled side sets the pin
    assign pin_a = o_pin_a_oe ? o_pin_a_out : src_a;
    assign pin_b = o_pin_b_oe ? o_pin_b_out : src_b;
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        nirq[0] <= nirq[0] + 32'(irq_a);
        nirq[1] <= nirq[1] + 32'(irq_b);
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input tmec_addr_t a, input tmec_byte_t d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rc(input tmec_addr_t a, input tmec_byte_t exp, input string what);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(32'(o_rdata), 32'(exp), what);
    endtask
    task automatic wait_irq(input int t, output int k);
        k = 0;
        while ((t ? irq_b : irq_a) !== 1'b1 && k < 20000) begin
            @(posedge i_mclk);
            #1;
            k++;
        end
        chk(32'(k < 20000), 1, "request wait");
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #600us;
        err_count++;
        $display("CHECK FAILED at %0t: timeout", $time);
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n, x, k, t, c, pol;
        {i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
        lfsr_q = 32'h04fc_5365;
        repeat (20) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rc(`TMEC_ADR_MODE_A, 8'h00, "mode a");
        rc(`TMEC_ADR_MODE_B, 8'h00, "mode b");
        rc(`TMEC_ADR_DIR1, 8'hff, "dir1");
        rc(16'h0000, 8'h00, "unmapped");
        x = lfsr();
        wr(`TMEC_ADR_DIR3, x[7:0]);
        rc(`TMEC_ADR_DIR3, x[7:0] | 8'hf0, "dir3");
        wr(`TMEC_ADR_MODE_B, 8'h7f);
        rc(`TMEC_ADR_MODE_B, 8'h43, "mode mask");
        wr(`TMEC_ADR_MODE_B, 8'h00);
        wr(`TMEC_ADR_DIR3, 8'hf7);
        wr(`TMEC_ADR_LAT3, 8'h08);
        wr(`TMEC_ADR_DIR1, 8'h7f);
        chk(32'({o_pin_a_oe, o_pin_b_oe}), 3, "pin enable");
        for (k = 0; k < 8; k++) begin
            wr(`TMEC_ADR_MODE_A, ptab[k]);
            chk(32'({o_pin_a_out, o_pin_b_out}), 32'({etab[k], 1'b1}), "static pin");
        end
        // Pwm active width is compare per period
        wr(`TMEC_ADR_CLK_A, 8'h02);
        x = lfsr() % 255 + 1;
        wr(`TMEC_ADR_CMP_A, tmec_byte_t'(x));
        for (pol = 0; pol < 2; pol++) begin
            wr(`TMEC_ADR_MODE_A, tmec_byte_t'(8'h41 | (pol << 1)));
            wr(`TMEC_ADR_MODE_A, tmec_byte_t'(8'hc1 | (pol << 1)));
            repeat (300) @(posedge i_mclk);
            n = 0;
            repeat (256) begin
                @(posedge i_mclk);
                #1;
                n += 32'(o_pin_a_out ^ pol[0]);
            end
            chk(n, x, "pwm width");
            wr(`TMEC_ADR_MODE_A, tmec_byte_t'(8'h41 | (pol << 1)));
            chk(32'(o_pin_a_out), pol, "pwm stop");
        end
        wr(`TMEC_ADR_MODE_A, 8'h00);
        wr(`TMEC_ADR_DIR1, 8'hff);
        wr(`TMEC_ADR_DIR3, 8'hff);
        for (t = 0; t < 2; t++) begin
            for (c = 2; c < 8; c++) begin
                n = (c == 7) ? 0 : lfsr() % 4;
                wr(amode[t], 8'h00);
                wr(aclk[t], tmec_byte_t'(c));
                wr(acmp[t], tmec_byte_t'(n));
                wr(amode[t], 8'h80);
                wait_irq(t, k);
                @(posedge i_mclk);
                #1;
                wait_irq(t, k);
                chk(k + 1, divs[t][c] * (n + 1), "interval");
            end
            wr(amode[t], 8'h00);
            rc(acnt[t], 8'h00, "stopped count");
            // Event counts on both edges, one match
            for (c = 0; c < 2; c++) begin
                n = lfsr() % 4 + 2;
                x = lfsr() % 2 + 1;
                wr(aclk[t], tmec_byte_t'(c));
                wr(acmp[t], tmec_byte_t'(n));
                wr(amode[t], 8'h80);
                k = nirq[t];
                if (t == 1) begin
                    i_src_b.pulses(n + 1 + x, 2 + c);
                end else begin
                    i_src_a.pulses(n + 1 + x, 2 + c);
                end
                repeat (8) @(posedge i_mclk);
                rc(acnt[t], tmec_byte_t'(x), "event count");
                chk(nirq[t] - k, 1, "event match");
                wr(amode[t], 8'h00);
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
